// [rtcics_top.sv]
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module rtcics_top #(
  parameter int SYS_DIV_W = 12
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Subclock level and power state
  input wire logic SUBCLK_I,
  input wire logic STANDBY_I,
  // Clock output pin and interrupt
  output logic TIMER_CLOCK_OUTPUT_PIN_O,
  output logic IRQ_O
);

  // ****************************************
  // Declarations
  // ****************************************
  logic ack_q;
  logic wr_en;
  logic rd_start;
  logic [7:0] wbyte;
  // Per-register write strobes
  logic wr_first_ctrl;
  logic wr_periodic_irq_enable;
  logic wr_clock_source_select;
  logic wr_irq_flag;
  logic wr_irq_mask;
  logic wr_port_mode;
  logic [31:0] readdata_q;
  logic [7:0] first_ctrl_q;
  logic [7:0] periodic_irq_enable_q;
  logic [7:0] clock_source_select_q;
  logic [7:0] irq_flag_register_q;
  logic [7:0] irq_mask_q;
  logic port_mode_q;
  logic [SYS_DIV_W-1:0] sys_div_q;
  logic sub_prev_q;
  logic sub_rise;
  logic [14:0] sub_cnt_q;
  logic [7:0] sec_q;
  logic [7:0] min_q;
  logic [7:0] hour_q;
  logic [2:0] day_q;
  logic [7:0] frc_q;
  logic timekeeping;
  logic running;
  logic frc_tick;
  logic quarter_ev;
  logic half_ev;
  logic sec_ev;
  logic min_ev;
  logic hour_ev;
  logic day_ev;
  logic week_ev;
  logic ovf_ev;
  logic [7:0] events;
  logic [7:0] flag_set;
  logic [7:0] flag_keep;
  logic pin_q;
  logic sel_clk;

  // Tick from the free-running prescaler for a given divide ratio
  function automatic logic div_tick(input logic [3:0] code, input logic [SYS_DIV_W-1:0] cnt);
    logic t;
    t = 1'b0;
    if (code == rtcics_pkg::SRC_DIV256) begin
      t = &cnt[7:0];
    end else if (code == rtcics_pkg::SRC_DIV512) begin
      t = &cnt[8:0];
    end else if (code == rtcics_pkg::SRC_DIV2048) begin
      t = &cnt[10:0];
    end else if (code == rtcics_pkg::SRC_DIV4096) begin
      t = &cnt[11:0];
    end
    return t;
  endfunction

  // Write strobe for one register offset
  function automatic logic wr_hit(input logic en, input logic [7:0] addr,
                                  input logic [7:0] ofs);
    logic hit;
    hit = en && (addr == ofs);
    return hit;
  endfunction

  // ****************************************
  // Avalon-MM handshake
  // ****************************************

  // One wait state per access, then the access completes
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
    end
  end

  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  assign wr_en = AVS_WRITE_I & ack_q & AVS_BYTEENABLE_I[0];
  assign rd_start = AVS_READ_I & ~ack_q;
  assign wbyte = AVS_WRITEDATA_I[7:0];
  assign AVS_READDATA_O = readdata_q;

  // One write strobe per writable register; seconds has none
  assign wr_first_ctrl = wr_hit(wr_en, AVS_ADDRESS_I, rtcics_pkg::OFS_FIRST_CTRL);
  assign wr_periodic_irq_enable = wr_hit(wr_en, AVS_ADDRESS_I, rtcics_pkg::OFS_PERIODIC_IRQ_EN);
  assign wr_clock_source_select = wr_hit(wr_en, AVS_ADDRESS_I, rtcics_pkg::OFS_CLK_SRC_SEL);
  assign wr_irq_flag = wr_hit(wr_en, AVS_ADDRESS_I, rtcics_pkg::OFS_IRQ_FLAG);
  assign wr_irq_mask = wr_hit(wr_en, AVS_ADDRESS_I, rtcics_pkg::OFS_IRQ_MASK);
  assign wr_port_mode = wr_hit(wr_en, AVS_ADDRESS_I, rtcics_pkg::OFS_PORT_MODE_THREE);

  // Read data captured in the wait cycle, stands through the completing edge
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      readdata_q <= 32'h0000_0000;
    end else if (rd_start) begin
      readdata_q <= 32'h0000_0000;
      if (AVS_ADDRESS_I == rtcics_pkg::OFS_FIRST_CTRL) begin
        readdata_q[7:0] <= first_ctrl_q & rtcics_pkg::FIRST_CTRL_RD_MASK;
      end else if (AVS_ADDRESS_I == rtcics_pkg::OFS_SECONDS) begin
        readdata_q[7:0] <= timekeeping ? sec_q : frc_q;
      end else if (AVS_ADDRESS_I == rtcics_pkg::OFS_PERIODIC_IRQ_EN) begin
        readdata_q[7:0] <= periodic_irq_enable_q;
      end else if (AVS_ADDRESS_I == rtcics_pkg::OFS_CLK_SRC_SEL) begin
        readdata_q[7:0] <= clock_source_select_q & rtcics_pkg::CLK_SRC_SEL_RD_MASK;
      end else if (AVS_ADDRESS_I == rtcics_pkg::OFS_IRQ_FLAG) begin
        readdata_q[7:0] <= irq_flag_register_q;
      end else if (AVS_ADDRESS_I == rtcics_pkg::OFS_IRQ_MASK) begin
        readdata_q[7:0] <= irq_mask_q;
      end else if (AVS_ADDRESS_I == rtcics_pkg::OFS_PORT_MODE_THREE) begin
        readdata_q[0] <= port_mode_q;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************

  // First control register: run, 12/24, pm, soft reset
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      first_ctrl_q <= 8'h00;
    end else if (wr_first_ctrl) begin
      first_ctrl_q <= wbyte & rtcics_pkg::FIRST_CTRL_RD_MASK;
    end
  end

  // Periodic and overflow enables
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      periodic_irq_enable_q <= 8'h00;
    end else if (wr_periodic_irq_enable) begin
      periodic_irq_enable_q <= wbyte;
    end
  end

  // Clock source select, bit 7 kept at zero
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      clock_source_select_q <= rtcics_pkg::CLK_SRC_SEL_RST;
    end else if (wr_clock_source_select) begin
      clock_source_select_q <= wbyte & rtcics_pkg::CLK_SRC_SEL_RD_MASK;
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      irq_mask_q <= 8'h00;
    end else if (wr_irq_mask) begin
      irq_mask_q <= wbyte;
    end
  end

  // Pin output enable
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      port_mode_q <= 1'b0;
    end else if (wr_port_mode) begin
      port_mode_q <= wbyte[rtcics_pkg::BIT_TIMER_CLOCK_OUTPUT_PIN];
    end
  end

  // ****************************************
  // Mode decode and prescalers
  // ****************************************

  // Only the subclock/4 code keeps time; anything else is counter mode
  assign timekeeping = clock_source_select_q[3:0] == rtcics_pkg::SRC_SUB_DIV4;
  // Run bit gates both modes; soft reset holds both modes stopped
  assign running = first_ctrl_q[rtcics_pkg::BIT_RUN] &
                   ~first_ctrl_q[rtcics_pkg::BIT_SOFT_RST];
  // Prohibited codes give no tick, so the counter simply holds
  assign frc_tick = div_tick(clock_source_select_q[3:0], sys_div_q);

  // System clock prescaler, always running
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      sys_div_q <= '0;
    end else begin
      sys_div_q <= sys_div_q + 1'b1;
    end
  end

  // Subclock edge detector
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      sub_prev_q <= 1'b0;
    end else begin
      sub_prev_q <= SUBCLK_I;
    end
  end

  assign sub_rise = SUBCLK_I & ~sub_prev_q;

  // ****************************************
  // Timekeeping on subclock/4
  // ****************************************

  // Subclock edge count within one second
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I || first_ctrl_q[rtcics_pkg::BIT_SOFT_RST]) begin
      sub_cnt_q <= 15'h0000;
    end else if (timekeeping && running && sub_rise) begin
      sub_cnt_q <= sub_cnt_q + 15'h0001;
    end
  end

  assign quarter_ev = timekeeping && running && sub_rise &&
                      (sub_cnt_q[12:0] == 13'(rtcics_pkg::QUARTER_EDGES - 1));
  assign half_ev = quarter_ev && sub_cnt_q[13];
  assign sec_ev = half_ev && sub_cnt_q[14];
  assign min_ev = sec_ev && (sec_q == rtcics_pkg::SECS_PER_MIN - 8'h01);
  assign hour_ev = min_ev && (min_q == rtcics_pkg::SECS_PER_MIN - 8'h01);
  assign day_ev = hour_ev && (hour_q == rtcics_pkg::HOURS_PER_DAY - 8'h01);
  assign week_ev = day_ev && (day_q == rtcics_pkg::DAYS_PER_WEEK - 3'h1);

  // Seconds, minutes and hours
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I || first_ctrl_q[rtcics_pkg::BIT_SOFT_RST]) begin
      sec_q <= 8'h00;
      min_q <= 8'h00;
      hour_q <= 8'h00;
    end else if (sec_ev) begin
      sec_q <= min_ev ? 8'h00 : sec_q + 8'h01;
      if (min_ev) begin
        min_q <= hour_ev ? 8'h00 : min_q + 8'h01;
      end
      if (hour_ev) begin
        hour_q <= day_ev ? 8'h00 : hour_q + 8'h01;
      end
    end
  end

  // Day of week, advanced at the end of each day
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I || first_ctrl_q[rtcics_pkg::BIT_SOFT_RST]) begin
      day_q <= 3'h0;
    end else if (day_ev) begin
      day_q <= week_ev ? 3'h0 : day_q + 3'h1;
    end
  end

  // ****************************************
  // Free-running counter
  // ****************************************

  // 8-bit counter on the divided system clock
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I || first_ctrl_q[rtcics_pkg::BIT_SOFT_RST]) begin
      frc_q <= 8'h00;
    end else if (!timekeeping && running && frc_tick) begin
      frc_q <= frc_q + 8'h01;
    end
  end

  assign ovf_ev = !timekeeping && running && frc_tick && (frc_q == 8'hFF);

  // ****************************************
  // Interrupt flags
  // ****************************************

  assign events = {ovf_ev, week_ev, day_ev, hour_ev, min_ev, sec_ev, half_ev, quarter_ev};
  // Enabled events only reach the flags
  assign flag_set = events & periodic_irq_enable_q;

  // Zero written clears, one written keeps
  assign flag_keep = wr_irq_flag ? wbyte : 8'hFF;

  // Sticky flags; a new event wins over a clearing write
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      irq_flag_register_q <= 8'h00;
    end else begin
      irq_flag_register_q <= (irq_flag_register_q & flag_keep) | flag_set;
    end
  end

  // Single level interrupt from unmasked flags
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_flag_register_q & irq_mask_q);
    end
  end

  // ****************************************
  // Clock output pin
  // ****************************************

  // Divided system clock stops in standby; subclock passes in any mode
  always_comb begin
    sel_clk = 1'b0;
    if (clock_source_select_q[rtcics_pkg::BIT_CLK_OUT_SUBCLOCK_SEL]) begin
      sel_clk = SUBCLK_I;
    end else if (!STANDBY_I) begin
      case (clock_source_select_q[6:5])
        rtcics_pkg::OUT_DIV4: sel_clk = sys_div_q[1];
        rtcics_pkg::OUT_DIV8: sel_clk = sys_div_q[2];
        rtcics_pkg::OUT_DIV16: sel_clk = sys_div_q[3];
        default: sel_clk = sys_div_q[4];
      endcase
    end
  end

  // Registered pin drive, low while the pin output is disabled
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= port_mode_q & sel_clk;
    end
  end

  assign TIMER_CLOCK_OUTPUT_PIN_O = pin_q;

endmodule

// [rtcics_pkg.sv]
// Operation
// - Enabled periodic event sets its flag bit
// - Overflow enable blocks or allows overflow interrupt
// - Week and day enables gate their interrupts
// - Hour and minute enables gate their interrupts
// - Second, half, quarter enables gate interrupts
// - Non-subclock source selects 8-bit free-running counter
// - Run bit starts and stops free-running counter
// - Seconds register reads counter in free-run mode
// - Counter overflow raises interrupt only when enabled
// - Clock-output field picks divided clock or subclock
// - Divided system clock output in active/sleep only
// - Source codes pick divider or subclock timekeeping
// - Source register bit 7 reads 0, resets 0x08
// - Run bit stops or starts counting operation
// - Flags stay set until written with zero
package rtcics_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_FIRST_CTRL = 8'h00;
  localparam logic [7:0] OFS_SECONDS = 8'h04;
  localparam logic [7:0] OFS_PERIODIC_IRQ_EN = 8'h08;
  localparam logic [7:0] OFS_CLK_SRC_SEL = 8'h0C;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_PORT_MODE_THREE = 8'h18;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int BIT_RUN = 7;
  localparam int BIT_HOUR24 = 6;
  localparam int BIT_PM = 5;
  localparam int BIT_SOFT_RST = 4;
  localparam int BIT_TIMER_CLOCK_OUTPUT_PIN = 0;
  localparam int BIT_CLK_OUT_SUBCLOCK_SEL = 4;
  // Flag / enable layout: 7 ovf, 6 week, 5 day, 4 hour, 3 min, 2 sec, 1 half, 0 quarter
  localparam int BIT_OVF = 7;
  localparam int BIT_WEEK = 6;
  localparam int BIT_DAY = 5;
  localparam int BIT_HOUR = 4;
  localparam int BIT_MIN = 3;
  localparam int BIT_SEC = 2;
  localparam int BIT_HALF = 1;
  localparam int BIT_QUARTER = 0;
  localparam logic [7:0] CLK_SRC_SEL_RST = 8'h08;
  localparam logic [7:0] CLK_SRC_SEL_RD_MASK = 8'h7F;
  localparam logic [7:0] FIRST_CTRL_RD_MASK = 8'hF0;

  // ****************************************
  // Clock source and clock output codes
  // ****************************************
  localparam logic [3:0] SRC_DIV256 = 4'h3;
  localparam logic [3:0] SRC_DIV512 = 4'h4;
  localparam logic [3:0] SRC_DIV2048 = 4'h5;
  localparam logic [3:0] SRC_DIV4096 = 4'h6;
  localparam logic [3:0] SRC_SUB_DIV4 = 4'h8;
  localparam logic [1:0] OUT_DIV4 = 2'h0;
  localparam logic [1:0] OUT_DIV8 = 2'h1;
  localparam logic [1:0] OUT_DIV16 = 2'h2;
  localparam logic [1:0] OUT_DIV32 = 2'h3;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam int SUBCLK_HZ = 32768;
  localparam int QUARTER_EDGES = SUBCLK_HZ / 4;
  localparam logic [7:0] SECS_PER_MIN = 8'h3C;
  localparam logic [7:0] HOURS_PER_DAY = 8'h18;
  localparam logic [2:0] DAYS_PER_WEEK = 3'h7;

endpackage

// [rtcics_top_props.sv]
`timescale 1ns/1ps
module rtcics_top_props (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  // Register bus
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // Pins
  input wire logic SUBCLK_I,
  input wire logic STANDBY_I,
  input wire logic TIMER_CLOCK_OUTPUT_PIN_O,
  input wire logic IRQ_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  // ****************************************
  // Bus transfer steps
  // ****************************************
  sequence req_wait;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence rd_done(a);
    AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == a;
  endsequence
  sequence mask_off;
    AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[7:0] == 8'h00
      && AVS_ADDRESS_I == rtcics_pkg::OFS_IRQ_MASK;
  endsequence
  // ****************************************
  // Checks
  // ****************************************
  one_wait_a: assert property (req_wait |=> !AVS_WAITREQUEST_O)
    else $error("waitrequest held past one wait state");
  idle_ready_a: assert property (!(AVS_READ_I || AVS_WRITE_I) |-> !AVS_WAITREQUEST_O)
    else $error("waitrequest high without request");
  upper_zero_a: assert property (AVS_READDATA_O[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  src_bit7_a: assert property (rd_done(rtcics_pkg::OFS_CLK_SRC_SEL) |-> !AVS_READDATA_O[7])
    else $error("source select bit 7 read as one");
  ctrl_low_a: assert property (rd_done(rtcics_pkg::OFS_FIRST_CTRL) |-> AVS_READDATA_O[3:0] == 4'h0)
    else $error("control low bits not zero");
  unmapped_a: assert property (AVS_READ_I && !AVS_WAITREQUEST_O
    && AVS_ADDRESS_I > rtcics_pkg::OFS_PORT_MODE_THREE |-> AVS_READDATA_O == 32'h00000000)
    else $error("unmapped read not zero");
  mask_irq_a: assert property (mask_off |-> ##2 !IRQ_O)
    else $error("interrupt stays high with mask cleared");
  irq_fall_a: assert property ($fell(IRQ_O) |-> $past(AVS_WRITE_I && !AVS_WAITREQUEST_O, 2))
    else $error("interrupt dropped without a write");
endmodule

bind rtcics_top rtcics_top_props i_props (.CLK_SYS_I, .RST_B_I, .AVS_ADDRESS_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_BYTEENABLE_I, .AVS_WRITEDATA_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O,
  .SUBCLK_I, .STANDBY_I, .TIMER_CLOCK_OUTPUT_PIN_O, .IRQ_O);

// [rtcics_top_test.sv]
`timescale 1ns/1ps
module rtcics_top_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic wait_req;
  logic sub = 1'b0;
  logic sub_en = 1'b0;
  logic stby = 1'b0;
  logic pin;
  logic irq;
  logic [7:0] exp_q[$];
  logic [7:0] r;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int k;

  rtcics_top i_dut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_req), .SUBCLK_I(sub), .STANDBY_I(stby),
    .TIMER_CLOCK_OUTPUT_PIN_O(pin), .IRQ_O(irq));

  // Clock, subclock and hang limit
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (sub_en) begin
      sub <= ~sub;
    end
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h000000, d};
    do @(posedge clk); while (wait_req !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask

  // Count pin rising edges over n cycles
  task automatic rises(input int n, output int c);
    logic p;
    c = 0;
    p = pin;
    repeat (n) begin
      @(negedge clk);
      if (pin && !p) c++;
      p = pin;
    end
  endtask

  // Compare each completed read with the oldest note
  always @(negedge clk) begin
    if (rd && wait_req === 1'b0) begin
      chk(rdata, {24'h000000, exp_q.pop_front()});
    end
  end

  initial begin
    void'($urandom(32'h67464313));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd8(rtcics_pkg::OFS_PERIODIC_IRQ_EN, 8'h00);
    rd8(rtcics_pkg::OFS_CLK_SRC_SEL, 8'h08);
    rd8(8'h1C, 8'h00);
    r = 8'($urandom());
    wr8(rtcics_pkg::OFS_PERIODIC_IRQ_EN, r);
    rd8(rtcics_pkg::OFS_PERIODIC_IRQ_EN, r);
    // A write with byte lane 0 off is ignored
    be <= 4'h0;
    wr8(rtcics_pkg::OFS_PERIODIC_IRQ_EN, ~r);
    be <= 4'hF;
    rd8(rtcics_pkg::OFS_PERIODIC_IRQ_EN, r);
    wr8(rtcics_pkg::OFS_CLK_SRC_SEL, 8'hF8);
    rd8(rtcics_pkg::OFS_CLK_SRC_SEL, 8'h78);
    for (int c = 3; c < 7; c++) begin
      wr8(rtcics_pkg::OFS_CLK_SRC_SEL, 8'(c));
      rd8(rtcics_pkg::OFS_CLK_SRC_SEL, 8'(c));
    end
    // Divided clocks on the pin, silent in standby
    wr8(rtcics_pkg::OFS_PORT_MODE_THREE, 8'h01);
    stby <= 1'b1;
    wr8(rtcics_pkg::OFS_CLK_SRC_SEL, rtcics_pkg::CLK_SRC_SEL_RST);
    rises(64, k);
    chk(k, 0);
    stby <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr8(rtcics_pkg::OFS_CLK_SRC_SEL, 8'(c << 5) | rtcics_pkg::CLK_SRC_SEL_RST);
      repeat (40) @(posedge clk);
      rises(128, k);
      chk(k, 32 >> c);
    end
    sub_en <= 1'b1;
    wr8(rtcics_pkg::OFS_CLK_SRC_SEL, 8'h18);
    repeat (40) @(posedge clk);
    rises(128, k);
    chk(k, 64);
    // Timekeeping with the quarter event disabled
    wr8(rtcics_pkg::OFS_IRQ_MASK, 8'hFF);
    wr8(rtcics_pkg::OFS_PERIODIC_IRQ_EN, 8'h7E);
    wr8(rtcics_pkg::OFS_CLK_SRC_SEL, rtcics_pkg::CLK_SRC_SEL_RST);
    wr8(rtcics_pkg::OFS_FIRST_CTRL, 8'h80);
    repeat (20000) @(posedge clk);
    chk(irq, 1'b0);
    rd8(rtcics_pkg::OFS_IRQ_FLAG, 8'h00);
    // Free-running counter on the divide-by-256 source
    wr8(rtcics_pkg::OFS_FIRST_CTRL, 8'h10);
    sub_en <= 1'b0;
    wr8(rtcics_pkg::OFS_CLK_SRC_SEL, 8'h03);
    wr8(rtcics_pkg::OFS_PERIODIC_IRQ_EN, 8'h80);
    wr8(rtcics_pkg::OFS_FIRST_CTRL, 8'h00);
    repeat (600) @(posedge clk);
    rd8(rtcics_pkg::OFS_SECONDS, 8'h00);
    wr8(rtcics_pkg::OFS_FIRST_CTRL, 8'h80);
    // Overflow fixes the prescaler phase, so the count below is exact
    for (int i = 0; i < 66000 && irq !== 1'b1; i++) @(posedge clk);
    repeat (1400) @(posedge clk);
    rd8(rtcics_pkg::OFS_SECONDS, 8'h05);
    rd8(rtcics_pkg::OFS_IRQ_FLAG, 8'h80);
    wr8(rtcics_pkg::OFS_IRQ_FLAG, 8'hFF);
    rd8(rtcics_pkg::OFS_IRQ_FLAG, 8'h80);
    wr8(rtcics_pkg::OFS_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr8(rtcics_pkg::OFS_IRQ_MASK, 8'hFF);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr8(rtcics_pkg::OFS_IRQ_FLAG, 8'h00);
    rd8(rtcics_pkg::OFS_IRQ_FLAG, 8'h00);
    chk(irq, 1'b0);
    test_done();
  end
endmodule
